// >>> shared/dbt_consts.svh
// Purpose: offsets, field limits, reset values and timing counts
// Assumes: 16-bit parameter registers, 125 MHz clock
// Notes: definitions only
`ifndef DBT_CONSTS_SVH
`define DBT_CONSTS_SVH
`define DBT_ADDR_CONTRAST 16'h0023
`define DBT_ADDR_OP_BRIGHT 16'h0024
`define DBT_ADDR_SCR_PROF 16'h0025
`define DBT_ADDR_ROT_PROF 16'h0026
`define DBT_ADDR_DWELL 16'h0027
`define DBT_ADDR_ENERGY_CLR 16'h01fb
`define DBT_ADDR_IDLE_TMO 16'h02ea
`define DBT_ADDR_SB_BRIGHT 16'h02eb
`define DBT_ENERGY_CLR_CMD 16'h0001
`define DBT_RST_CONTRAST 4'h5
`define DBT_RST_OP_BRIGHT 4'h6
`define DBT_RST_SB_BRIGHT 4'h0
`define DBT_RST_SCR_PROF 2'h0
`define DBT_RST_ROT_PROF 2'h0
`define DBT_RST_DWELL 6'h00
`define DBT_RST_IDLE_TMO 14'h0384
`define DBT_LEVEL_MAX 16'h0009
`define DBT_PROF_MAX 16'h0003
`define DBT_DWELL_MAX 16'h003c
`define DBT_IDLE_MIN 16'h003c
`define DBT_IDLE_MAX 16'h270f
`define DBT_MANUAL_HOLD_S 6'h3c
`define DBT_BRIGHT_MAX 4'h9
`define DBT_BRIGHT_MIN 4'h0
`define DBT_HARM_ORDER_MAX 6'h28
`define DBT_FUND_HZ_MIN 8'h2d
`define DBT_FUND_HZ_MAX 8'h41
`define DBT_SECS_PER_TENTH_H 9'h168
`define DBT_SECS_PER_HOUR 12'he10
`define DBT_HOURS_TENTHS_MAX 20'hf423f
`define DBT_COMP_SECS_MAX 20'hf423f
`define DBT_THD_SCALE 30'h3e8
`define DBT_FLASH_HALF_MS 500
`define DBT_CLK_KHZ 125000
`define DBT_FLASH_HALF_CYC (`DBT_FLASH_HALF_MS * `DBT_CLK_KHZ)
`endif

// >>> shared/dbt_pkg.sv
// Purpose: types shared by the display and timekeeping block
// Assumes: nothing
// Notes: constants live in dbt_consts.svh
package dbt_pkg;
  typedef enum logic [0:0] {
    DBT_MANUAL = 1'b0,
    DBT_ROTATE = 1'b1
  } dbt_view_t;
  typedef enum logic [1:0] {
    DBT_THD_COLLECT = 2'b00,
    DBT_THD_SQRT = 2'b01,
    DBT_THD_DIV = 2'b10
  } dbt_thd_st_t;
endpackage

// >>> tb/dbt_panel_model.sv
// Purpose: front panel keys and one-second time base
// Assumes: keys are clean levels held by the bench
// Notes: first tick comes late so the reset synchroniser has settled
`timescale 1ns/10ps
module dbt_panel_model #(parameter int TICK = 4) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] press_i,
  output logic sec_tick_o,
  output logic [2:0] buttons_o
);
  int cnt_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= -8;
      sec_tick_o <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == TICK - 1) ? 0 : cnt_q + 1;
      sec_tick_o <= (cnt_q == TICK - 1);
    end
  end
  // any of the three keys is activity
  assign buttons_o = press_i;
endmodule // dbt_panel_model

// >>> tb/dbt_top_assertions.sv
// Purpose: port-level checks of the display and timekeeping block
// Assumes: FLASH_HALF_CYC set small in simulation
// Notes: bound from the bench top
`timescale 1ns/10ps
module dbt_top_assertions (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic sec_tick_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  input logic [15:0] param_rdata_o,
  input logic energy_clear_o,
  input wire logic [7:0] fund_hz_i,
  input logic harm_ok_o,
  input logic [3:0] lcd_contrast_o,
  input logic [3:0] backlight_level_o,
  input wire logic identify_i,
  input wire logic [2:0] log_sel_i,
  input logic [2:0] log_tag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic clr_w;
  assign clr_w = ce_i && param_wr_i && param_addr_i == 16'h01fb &&
    param_wdata_i == 16'h0001;
  energy_clr_a: assert property (clr_w |=> energy_clear_o)
    else $error("energy clear pulse missing");
  energy_src_a: assert property (energy_clear_o |-> $past(clr_w))
    else $error("energy clear without command");
  harm_ok_a: assert property (harm_ok_o ==
    (fund_hz_i >= 8'h2d && fund_hz_i <= 8'h41))
    else $error("harmonic valid flag wrong");
  contrast_rng_a: assert property (lcd_contrast_o <= 4'h9)
    else $error("contrast out of range");
  bright_rng_a: assert property (backlight_level_o <= 4'h9)
    else $error("backlight out of range");
  rd_contrast_a: assert property (ce_i && param_rd_i && !param_wr_i &&
    param_addr_i == 16'h0023 |=> param_rdata_o == {12'h000, lcd_contrast_o})
    else $error("contrast readback wrong");
  bad_write_a: assert property (ce_i && param_wr_i &&
    param_addr_i == 16'h0023 && param_wdata_i > 16'h0009 |=>
    $stable(lcd_contrast_o))
    else $error("bad contrast accepted");
  log_tag_a: assert property (ce_i && sec_tick_i &&
    log_sel_i <= 3'h6 |=> log_tag_o == $past(log_sel_i))
    else $error("log tag wrong");
  flash_max_a: assert property ($rose(identify_i) |->
    ##[1:12] backlight_level_o == 4'h9)
    else $error("identify flash missing");
  cover property (energy_clear_o);
  cover property (identify_i && backlight_level_o == 4'h0);
  cover property (sec_tick_i && log_tag_o == 3'h1);
endmodule // dbt_top_assertions

// >>> tb/dbt_top_tb.sv
// Purpose: self-checking bench of the display and timekeeping block
// Assumes: one tick every four cycles from the panel model
// Notes: random write data from an lfsr seeded with 26
`timescale 1ns/10ps
module dbt_top_tb;
  logic clk_i = 0, reset_n_i = 0, ce_i = 0, param_wr_i = 0, param_rd_i = 0;
  logic identify_i = 0, measuring_i = 0, comp_time_clear_i = 0;
  logic sec_tick_i, energy_clear_o, harm_ok_o, log_in_hours_o;
  logic [2:0] press = 0, buttons_i, log_sel_i = 0, log_tag_o;
  logic [15:0] param_addr_i = 0, param_wdata_i = 0, param_rdata_o, v, d;
  logic [7:0] fund_hz_i = 8'h32;
  logic [5:0] comp_violation_i = 0;
  logic [1:0] screen_profile_o, rotation_profile_o;
  logic [3:0] lcd_contrast_o, backlight_level_o;
  logic [19:0] log_value_o;
  logic hv = 0, ro;
  logic [5:0] ho = 0;
  logic [15:0] hm = 0, ti;
  logic [7:0] rm = 0;
  logic [2:0] si;
  logic [15:0] lf = 16'h001a;
  int failures = 0, checked = 0, j, k;
  logic [15:0] ad [7] = '{16'h0023, 16'h0024, 16'h0025, 16'h0026,
    16'h0027, 16'h02ea, 16'h02eb};
  logic [15:0] sh [7] = '{5, 6, 0, 0, 0, 900, 0};
  logic [15:0] bad [7] = '{10, 10, 4, 4, 61, 59, 10};
  logic [15:0] good [7] = '{9, 0, 3, 3, 60, 9999, 9};
  always #4 clk_i = ~clk_i;
  dbt_panel_model pm_u (.clk_i, .reset_n_i, .press_i(press),
    .sec_tick_o(sec_tick_i), .buttons_o(buttons_i));
  dbt_top #(.NSCR(8), .FLASH_HALF_CYC(4)) dut_u (.clk_i, .reset_n_i, .ce_i,
    .sec_tick_i, .buttons_i, .param_wr_i, .param_rd_i, .param_addr_i,
    .param_wdata_i, .param_rdata_o, .energy_clear_o, .fund_hz_i,
    .harm_valid_i(hv), .harm_order_i(ho), .harm_mag_i(hm),
    .harm_is_volt_i(1'b0), .harm_ok_o, .thd_i_o(ti), .thd_u_o(),
    .rot_mask_i(rm), .screen_profile_o, .rotation_profile_o,
    .screen_idx_o(si), .rotating_o(ro), .lcd_contrast_o, .backlight_level_o,
    .identify_i, .measuring_i, .comp_violation_i, .comp_time_clear_i,
    .log_sel_i, .log_tag_o, .log_value_o, .log_in_hours_o);
  function automatic logic [15:0] lfsr();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  function automatic logic [15:0] lim(input logic [15:0] a);
    case (a)
      16'h0025, 16'h0026: return 16'h0003;
      16'h0027: return 16'h003c;
      16'h02ea: return 16'h270f;
      default: return 16'h0009;
    endcase
  endfunction
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] dd);
    @(posedge clk_i);
    param_wr_i <= 1'b1;
    param_addr_i <= a;
    param_wdata_i <= dd;
    @(posedge clk_i);
    param_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] q);
    @(posedge clk_i);
    param_rd_i <= 1'b1;
    param_addr_i <= a;
    @(posedge clk_i);
    param_rd_i <= 1'b0;
    #1 q = param_rdata_o;
  endtask
  task automatic press_key(input logic [2:0] b);
    @(posedge clk_i);
    press <= b;
    repeat (6) @(posedge clk_i);
    press <= 3'h0;
    repeat (5) @(posedge clk_i);
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (sec_tick_i !== 1'b1 && k < 20);
      if (k >= 20) begin
        failures++;
        wrap_up();
      end
    end
  endtask
  task automatic wait_lvl(input logic [3:0] lv);
    k = 0;
    while (backlight_level_o !== lv && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 40) begin
      failures++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    ce_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], v);
      chk(v, sh[i]);
    end
    rd(16'h0100, v);
    chk(v, 0);
    wr(16'h01fb, 16'h0002);
    #1 chk(energy_clear_o, 0);
    wr(16'h01fb, 16'h0001);
    #1 chk(energy_clear_o, 1);
    @(posedge clk_i);
    #1 chk(energy_clear_o, 0);
    $display("test registers done");
    for (int i = 0; i < 35; i++) begin
      j = i % 7;
      d = i < 7 ? bad[j] : i < 14 ? good[j] : lfsr() % (lim(ad[j]) + 3);
      if (d <= lim(ad[j]) && (j != 5 || d >= 16'h003c))
        sh[j] = d;
      wr(ad[j], d);
      fund_hz_i <= 8'h28 + {3'h0, lf[4:0]};
      rd(ad[j], v);
      chk(v, sh[j]);
    end
    chk(lcd_contrast_o, sh[0]);
    chk(screen_profile_o, sh[2]);
    chk(rotation_profile_o, sh[3]);
    $display("test random writes done");
    wr(16'h0027, 16'h0001);
    rm <= 8'h05;
    wr(16'h0024, 16'h0007);
    wr(16'h02eb, 16'h0002);
    wr(16'h02ea, 16'h003c);
    press_key(3'h4);
    #1 chk(backlight_level_o, 7);
    ticks(50);
    #1 chk(backlight_level_o, 7);
    ticks(15);
    #1 chk(backlight_level_o, 2);
    press_key(3'h2);
    #1 chk(backlight_level_o, 7);
    @(posedge clk_i);
    identify_i <= 1'b1;
    wait_lvl(4'h9);
    chk(backlight_level_o, 9);
    wait_lvl(4'h0);
    chk(backlight_level_o, 0);
    identify_i <= 1'b0;
    $display("test backlight done");
    ticks(1);
    measuring_i <= 1'b1;
    ticks(360);
    measuring_i <= 1'b0;
    comp_violation_i <= 6'h01;
    log_sel_i <= 3'h1;
    ticks(5);
    comp_violation_i <= 6'h00;
    ticks(2);
    #1 chk(log_value_o, 5);
    chk(log_in_hours_o, 0);
    chk(log_tag_o, 1);
    @(posedge clk_i);
    comp_time_clear_i <= 1'b1;
    log_sel_i <= 3'h0;
    @(posedge clk_i);
    comp_time_clear_i <= 1'b0;
    ticks(2);
    #1 chk(log_value_o, 1);
    log_sel_i <= 3'h1;
    ticks(2);
    #1 chk(log_value_o, 0);
    chk(ro, 1);
    chk(si & 3'h5, 0);
    press_key(3'h1);
    #1 chk(ro, 0);
    chk(si[0], 1);
    $display("test time log done");
    fund_hz_i <= 8'h32;
    for (int n = 1; n <= 40; n++) begin
      @(posedge clk_i);
      hv <= 1'b1;
      ho <= 6'(n);
      hm <= n == 1 ? 16'h0064 : n == 2 ? 16'h001e : 16'h0000;
    end
    @(posedge clk_i);
    hv <= 1'b0;
    repeat (60) @(posedge clk_i);
    #1 chk(ti, 16'h012c);
    $display("test thd done");
    wrap_up();
  end
endmodule // dbt_top_tb
bind dbt_top dbt_top_assertions chk_u (.clk_i, .reset_n_i, .ce_i, .sec_tick_i,
  .param_wr_i, .param_rd_i, .param_addr_i, .param_wdata_i, .param_rdata_o,
  .energy_clear_o, .fund_hz_i, .harm_ok_o, .lcd_contrast_o,
  .backlight_level_o, .identify_i, .log_sel_i, .log_tag_o);

// >>> verilog/dbt_top.sv
// Purpose: front panel, backlight, thd and time logging of a power analyser
// Assumes: sec_tick_i is a one-cycle pulse each second from this clock
// Notes: parameter registers reached through the param_* port
// Functional notes
// - writing 001 to 507 clears all three energy counters together only
// - harmonics captured up to order forty, current in amps, voltage volts
// - harmonic analysis valid only for fundamental between 45 and 65 Hz
// - thd is root of summed squares from order two over fundamental
// - values recalculated each 10/12 periods, screens refreshed each second
// - rotation runs only when a rotation screen has nonzero time
// - buttons step screens; sixty idle seconds return to rotation
// - dwell 0 to 60 s shared by all profiles; zero stops advancing
// - rotation profile 0..2 preassigned, 3 customer defined
// - screen profile 0..2 fixed, 3 customer defined
// - after power returns show first screen of selected profile
// - contrast 0 to 9, zero lightest, default five
// - operating brightness on any button press and on restart
// - standby brightness after idle period 60..9999 s, default 900
// - any of three buttons restores operating level, restarts idle timer
// - operating brightness 0 to 9, default six
// - standby brightness 0 to 9, default zero
// - identify request flashes backlight between maximum and minimum
// - operating hours count in tenths while measuring, never cleared
// - displayed operating hours limited to 99999.9
// - comparator totals count violation time, seconds then hours
// - time logs tagged 1..6 for 1A,2A,1B,2B,1C,2C; hours untagged
// - comparator time reset clears all six, remote path only
`timescale 1ns/10ps
`include "dbt_consts.svh"
module dbt_top #(
  parameter int NSCR = 8,
  parameter int FLASH_HALF_CYC = `DBT_FLASH_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic sec_tick_i,
  input wire logic [2:0] buttons_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  output logic [15:0] param_rdata_o,
  output logic energy_clear_o,
  input wire logic [7:0] fund_hz_i,
  input wire logic harm_valid_i,
  input wire logic [5:0] harm_order_i,
  input wire logic [15:0] harm_mag_i,
  input wire logic harm_is_volt_i,
  output logic harm_ok_o,
  output logic [15:0] thd_i_o,
  output logic [15:0] thd_u_o,
  input wire logic [NSCR-1:0] rot_mask_i,
  output logic [1:0] screen_profile_o,
  output logic [1:0] rotation_profile_o,
  output logic [$clog2(NSCR)-1:0] screen_idx_o,
  output logic rotating_o,
  output logic [3:0] lcd_contrast_o,
  output logic [3:0] backlight_level_o,
  input wire logic identify_i,
  input wire logic measuring_i,
  input wire logic [5:0] comp_violation_i,
  input wire logic comp_time_clear_i,
  input wire logic [2:0] log_sel_i,
  output logic [2:0] log_tag_o,
  output logic [19:0] log_value_o,
  output logic log_in_hours_o
);
  localparam int IW = $clog2(NSCR);

  if (NSCR < 2 || (1 << IW) != NSCR) begin : g_chk
    $error("dbt_top: NSCR must be a power of two, at least 2");
  end

  function automatic logic fits(input logic [15:0] v, input logic [15:0] lo,
                                input logic [15:0] hi);
    fits = (v >= lo) && (v <= hi);
  endfunction

  // next selected screen after cur, wrapping; cur if none selected
  function automatic logic [IW-1:0] next_sel(input logic [NSCR-1:0] m,
                                             input logic [IW-1:0] cur);
    logic [IW-1:0] k;
    logic found;
    next_sel = cur;
    found = 1'b0;
    for (int j = 1; j <= NSCR; j++) begin
      k = IW'(cur + IW'(j));
      if (!found && m[k]) begin
        next_sel = k;
        found = 1'b1;
      end
    end
  endfunction

  // reset release and pin synchronisers
  logic rst_s1_q, rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  logic [2:0] btn_s1_q, btn_s2_q, btn_s3_q, btn_q;
  logic [2:0] press;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      btn_s1_q <= 3'h0;
      btn_s2_q <= 3'h0;
      btn_s3_q <= 3'h0;
      btn_q <= 3'h0;
    end else if (ce_i) begin
      btn_s1_q <= buttons_i;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
      for (int b = 0; b < 3; b++) begin
        if (btn_s2_q[b] == btn_s3_q[b]) begin
          btn_q[b] <= btn_s3_q[b];
        end
      end
    end
  end
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      press[b] = (btn_s2_q[b] == btn_s3_q[b]) && btn_s3_q[b] && !btn_q[b];
    end
  end
  wire any_press = ce_i && (press != 3'h0);
  wire tick = ce_i && sec_tick_i;

  // parameter registers
  logic [3:0] contrast_q, op_bright_q, sb_bright_q;
  logic [1:0] scr_prof_q, rot_prof_q;
  logic [5:0] dwell_q;
  logic [13:0] idle_tmo_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      contrast_q <= `DBT_RST_CONTRAST;
      op_bright_q <= `DBT_RST_OP_BRIGHT;
      sb_bright_q <= `DBT_RST_SB_BRIGHT;
      scr_prof_q <= `DBT_RST_SCR_PROF;
      rot_prof_q <= `DBT_RST_ROT_PROF;
      dwell_q <= `DBT_RST_DWELL;
      idle_tmo_q <= `DBT_RST_IDLE_TMO;
    end else if (ce_i && param_wr_i) begin
      // bad values leave the old setting untouched
      case (param_addr_i)
        `DBT_ADDR_CONTRAST:
          if (fits(param_wdata_i, 16'h0, `DBT_LEVEL_MAX)) begin
            contrast_q <= param_wdata_i[3:0];
          end
        `DBT_ADDR_OP_BRIGHT:
          if (fits(param_wdata_i, 16'h0, `DBT_LEVEL_MAX)) begin
            op_bright_q <= param_wdata_i[3:0];
          end
        `DBT_ADDR_SB_BRIGHT:
          if (fits(param_wdata_i, 16'h0, `DBT_LEVEL_MAX)) begin
            sb_bright_q <= param_wdata_i[3:0];
          end
        `DBT_ADDR_SCR_PROF:
          if (fits(param_wdata_i, 16'h0, `DBT_PROF_MAX)) begin
            scr_prof_q <= param_wdata_i[1:0];
          end
        `DBT_ADDR_ROT_PROF:
          if (fits(param_wdata_i, 16'h0, `DBT_PROF_MAX)) begin
            rot_prof_q <= param_wdata_i[1:0];
          end
        `DBT_ADDR_DWELL:
          if (fits(param_wdata_i, 16'h0, `DBT_DWELL_MAX)) begin
            dwell_q <= param_wdata_i[5:0];
          end
        `DBT_ADDR_IDLE_TMO:
          if (fits(param_wdata_i, `DBT_IDLE_MIN, `DBT_IDLE_MAX)) begin
            idle_tmo_q <= param_wdata_i[13:0];
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      param_rdata_o <= 16'h0;
      energy_clear_o <= 1'b0;
    end else if (ce_i) begin
      // single strobe feeds all three energy counters
      energy_clear_o <= param_wr_i && param_addr_i == `DBT_ADDR_ENERGY_CLR
                        && param_wdata_i == `DBT_ENERGY_CLR_CMD;
      if (param_rd_i) begin
        case (param_addr_i)
          `DBT_ADDR_CONTRAST: param_rdata_o <= {12'h0, contrast_q};
          `DBT_ADDR_OP_BRIGHT: param_rdata_o <= {12'h0, op_bright_q};
          `DBT_ADDR_SB_BRIGHT: param_rdata_o <= {12'h0, sb_bright_q};
          `DBT_ADDR_SCR_PROF: param_rdata_o <= {14'h0, scr_prof_q};
          `DBT_ADDR_ROT_PROF: param_rdata_o <= {14'h0, rot_prof_q};
          `DBT_ADDR_DWELL: param_rdata_o <= {10'h0, dwell_q};
          `DBT_ADDR_IDLE_TMO: param_rdata_o <= {2'h0, idle_tmo_q};
          default: param_rdata_o <= 16'h0;
        endcase
      end
    end else begin
      energy_clear_o <= 1'b0;
    end
  end
  assign lcd_contrast_o = contrast_q;
  assign screen_profile_o = scr_prof_q;
  assign rotation_profile_o = rot_prof_q;

  // screen selection: manual browsing and timed rotation
  dbt_pkg::dbt_view_t view_q;
  logic [IW-1:0] scr_q;
  logic [5:0] hold_q, dwell_cnt_q;
  logic prof_chg;
  logic [1:0] scr_prof_seen_q;
  wire rot_able = (rot_mask_i != '0) && (dwell_q != 6'h0);
  assign prof_chg = scr_prof_seen_q != scr_prof_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      view_q <= dbt_pkg::DBT_MANUAL;
      scr_q <= '0;
      hold_q <= 6'h0;
      dwell_cnt_q <= 6'h0;
      scr_prof_seen_q <= `DBT_RST_SCR_PROF;
    end else if (ce_i) begin
      scr_prof_seen_q <= scr_prof_q;
      if (any_press) begin
        // buttons stay live during rotation
        view_q <= dbt_pkg::DBT_MANUAL;
        hold_q <= 6'h0;
        if (press[0]) begin
          scr_q <= IW'(scr_q + 1'b1);
        end else if (press[1]) begin
          scr_q <= IW'(scr_q - 1'b1);
        end
      end else if (prof_chg) begin
        scr_q <= '0;
      end else if (tick) begin
        case (view_q)
          dbt_pkg::DBT_MANUAL: begin
            if (hold_q >= `DBT_MANUAL_HOLD_S - 6'h1) begin
              hold_q <= 6'h0;
              if (rot_able) begin
                view_q <= dbt_pkg::DBT_ROTATE;
                dwell_cnt_q <= 6'h0;
                scr_q <= next_sel(rot_mask_i, scr_q);
              end
            end else begin
              hold_q <= hold_q + 6'h1;
            end
          end
          dbt_pkg::DBT_ROTATE: begin
            if (!rot_able) begin
              // zero dwell parks on the current screen
              dwell_cnt_q <= 6'h0;
            end else if (dwell_cnt_q >= dwell_q - 6'h1) begin
              dwell_cnt_q <= 6'h0;
              scr_q <= next_sel(rot_mask_i, scr_q);
            end else begin
              dwell_cnt_q <= dwell_cnt_q + 6'h1;
            end
          end
          default: view_q <= dbt_pkg::DBT_MANUAL;
        endcase
      end
    end
  end
  assign screen_idx_o = scr_q;
  assign rotating_o = view_q == dbt_pkg::DBT_ROTATE;

  // backlight: operating, standby, identify flash
  logic standby_q, flash_ph_q;
  logic [13:0] idle_q;
  logic [31:0] flash_cnt_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      standby_q <= 1'b0;
      idle_q <= 14'h0;
    end else if (ce_i) begin
      if (any_press) begin
        standby_q <= 1'b0;
        idle_q <= 14'h0;
      end else if (tick && !standby_q) begin
        if (idle_q >= idle_tmo_q - 14'h1) begin
          standby_q <= 1'b1;
        end else begin
          idle_q <= idle_q + 14'h1;
        end
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_q <= 32'h0;
      flash_ph_q <= 1'b0;
    end else if (ce_i) begin
      if (!identify_i) begin
        flash_cnt_q <= 32'h0;
        flash_ph_q <= 1'b0;
      end else if (flash_cnt_q >= 32'(FLASH_HALF_CYC - 1)) begin
        flash_cnt_q <= 32'h0;
        flash_ph_q <= !flash_ph_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      backlight_level_o <= `DBT_RST_OP_BRIGHT;
    end else if (ce_i) begin
      if (identify_i) begin
        backlight_level_o <= flash_ph_q ? `DBT_BRIGHT_MIN
                                        : `DBT_BRIGHT_MAX;
      end else begin
        // equal levels simply give no visible step
        backlight_level_o <= standby_q ? sb_bright_q : op_bright_q;
      end
    end
  end

  // operating hours in tenths, no clear input at all
  logic [8:0] oh_sec_q;
  logic [19:0] oh_tenths_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oh_sec_q <= 9'h0;
      oh_tenths_q <= 20'h0;
    end else if (tick && measuring_i) begin
      if (oh_sec_q >= `DBT_SECS_PER_TENTH_H - 9'h1) begin
        oh_sec_q <= 9'h0;
        if (oh_tenths_q < `DBT_HOURS_TENTHS_MAX) begin
          oh_tenths_q <= oh_tenths_q + 20'h1;
        end
      end else begin
        oh_sec_q <= oh_sec_q + 9'h1;
      end
    end
  end

  // comparator running-time totals
  logic [19:0] cmp_secs_q [6];
  logic [11:0] cmp_hsec_q [6];
  logic [19:0] cmp_hours_q [6];
  for (genvar g = 0; g < 6; g++) begin : g_cmp
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cmp_secs_q[g] <= 20'h0;
        cmp_hsec_q[g] <= 12'h0;
        cmp_hours_q[g] <= 20'h0;
      end else if (ce_i && comp_time_clear_i) begin
        // all six at once, remote strobe only
        cmp_secs_q[g] <= 20'h0;
        cmp_hsec_q[g] <= 12'h0;
        cmp_hours_q[g] <= 20'h0;
      end else if (tick && comp_violation_i[g]) begin
        if (cmp_secs_q[g] <= `DBT_COMP_SECS_MAX) begin
          cmp_secs_q[g] <= cmp_secs_q[g] + 20'h1;
        end
        if (cmp_hsec_q[g] >= `DBT_SECS_PER_HOUR - 12'h1) begin
          cmp_hsec_q[g] <= 12'h0;
          if (cmp_hours_q[g] != 20'hfffff) begin
            cmp_hours_q[g] <= cmp_hours_q[g] + 20'h1;
          end
        end else begin
          cmp_hsec_q[g] <= cmp_hsec_q[g] + 12'h1;
        end
      end
    end
  end

  // display values latched once a second; upstream recomputes each
  // 10/12 periods, so finer refresh would only flicker digits
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      log_tag_o <= 3'h0;
      log_value_o <= 20'h0;
      log_in_hours_o <= 1'b1;
    end else if (tick) begin
      log_tag_o <= 3'h0;
      log_value_o <= oh_tenths_q;
      log_in_hours_o <= 1'b1;
      for (int c = 0; c < 6; c++) begin
        if (log_sel_i == 3'(c + 1)) begin
          log_tag_o <= 3'(c + 1);
          if (cmp_secs_q[c] > `DBT_COMP_SECS_MAX) begin
            log_value_o <= cmp_hours_q[c];
            log_in_hours_o <= 1'b1;
          end else begin
            log_value_o <= cmp_secs_q[c];
            log_in_hours_o <= 1'b0;
          end
        end
      end
    end
  end

  // thd: collect orders 1..40, then square root, then ratio in permille
  dbt_pkg::dbt_thd_st_t thd_st_q;
  logic [15:0] fund_q;
  logic [39:0] acc_q, one_q, res_q;
  logic [29:0] num_q;
  logic [16:0] rem_q;
  logic [4:0] cnt_q;
  logic volt_q;
  logic [16:0] trial;
  assign harm_ok_o = fund_hz_i >= `DBT_FUND_HZ_MIN
                     && fund_hz_i <= `DBT_FUND_HZ_MAX;
  assign trial = {rem_q[15:0], num_q[29]};
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      thd_st_q <= dbt_pkg::DBT_THD_COLLECT;
      fund_q <= 16'h0;
      acc_q <= 40'h0;
      one_q <= 40'h0;
      res_q <= 40'h0;
      num_q <= 30'h0;
      rem_q <= 17'h0;
      cnt_q <= 5'h0;
      volt_q <= 1'b0;
      thd_i_o <= 16'h0;
      thd_u_o <= 16'h0;
    end else if (ce_i) begin
      case (thd_st_q)
        dbt_pkg::DBT_THD_COLLECT: begin
          // sets outside 45..65 Hz or beyond order 40 are dropped
          if (harm_valid_i && harm_ok_o) begin
            if (harm_order_i == 6'h1) begin
              fund_q <= harm_mag_i;
              acc_q <= 40'h0;
              volt_q <= harm_is_volt_i;
            end else if (harm_order_i >= 6'h2
                         && harm_order_i <= `DBT_HARM_ORDER_MAX) begin
              acc_q <= acc_q + 40'(harm_mag_i * harm_mag_i);
              if (harm_order_i == `DBT_HARM_ORDER_MAX) begin
                thd_st_q <= dbt_pkg::DBT_THD_SQRT;
                one_q <= 40'h40_0000_0000;
                res_q <= 40'h0;
              end
            end
          end
        end
        dbt_pkg::DBT_THD_SQRT: begin
          if (one_q == 40'h0) begin
            num_q <= 30'(res_q[19:0] * `DBT_THD_SCALE);
            rem_q <= 17'h0;
            cnt_q <= 5'h0;
            thd_st_q <= dbt_pkg::DBT_THD_DIV;
          end else begin
            if (acc_q >= res_q + one_q) begin
              acc_q <= acc_q - (res_q + one_q);
              res_q <= (res_q >> 1) + one_q;
            end else begin
              res_q <= res_q >> 1;
            end
            one_q <= one_q >> 2;
          end
        end
        dbt_pkg::DBT_THD_DIV: begin
          if (cnt_q == 5'd30) begin
            thd_st_q <= dbt_pkg::DBT_THD_COLLECT;
            // zero fundamental or huge ratio saturates the reading
            if (volt_q) begin
              thd_u_o <= (fund_q == 16'h0 || num_q[29:16] != 14'h0)
                         ? 16'hffff : num_q[15:0];
            end else begin
              thd_i_o <= (fund_q == 16'h0 || num_q[29:16] != 14'h0)
                         ? 16'hffff : num_q[15:0];
            end
          end else begin
            cnt_q <= cnt_q + 5'h1;
            if (trial >= {1'b0, fund_q}) begin
              rem_q <= trial - {1'b0, fund_q};
              num_q <= {num_q[28:0], 1'b1};
            end else begin
              rem_q <= trial;
              num_q <= {num_q[28:0], 1'b0};
            end
          end
        end
        default: thd_st_q <= dbt_pkg::DBT_THD_COLLECT;
      endcase
    end
  end
endmodule // dbt_top
